// File: core/vtf_pkg.sv
// Purpose: Shared constants and types of the VLAN tag forwarding block
// Assumes: APB register access, byte-wide frame stream, four switch ports
// Notes:   Offsets are byte addresses on the APB bus
package vtf_pkg;
  localparam int NPORT = 4;
  localparam int NVLAN = 8;
  localparam int AW = 11;
  localparam int MEM_DEPTH = 2048;
  // Frame geometry in bytes
  localparam logic [11:0] HDR_LEN = 12'h00c;
  localparam logic [11:0] TAG_LEN = 12'h004;
  localparam logic [11:0] FCS_LEN = 12'h004;
  localparam logic [11:0] MAX_FRAME = 12'h7fc;
  localparam logic [11:0] MIN_UNTAG = 12'h012;
  localparam logic [11:0] MIN_TAG = 12'h016;
  localparam logic [15:0] TPID = 16'h8100;
  localparam logic [11:0] VID_PRIO = 12'h000;
  localparam logic [11:0] VID_RSVD = 12'hfff;
  localparam logic [11:0] PVID_RST = 12'h001;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  // Register byte offsets
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam logic [11:0] REG_CMD = 12'h008;
  localparam logic [11:0] REG_PORT0 = 12'h010;
  localparam logic [11:0] REG_VLAN0 = 12'h040;
  // Port configuration fields
  localparam int PC_PVID_LSB = 0;
  localparam int PC_PRI_LSB = 12;
  localparam int PC_ACC_LSB = 15;
  localparam int PC_FILT_BIT = 17;
  localparam int PC_TRUNK_BIT = 18;
  localparam logic [31:0] PC_MASK = 32'h0007ffff;
  localparam logic [31:0] PC_RST = 32'h00000001;
  // VLAN entry fields
  localparam int VE_VID_LSB = 0;
  localparam int VE_VALID_BIT = 12;
  localparam int VE_CTL_LSB = 13;
  localparam int VE_TAG_LSB = 21;
  localparam int VE_DYN_LSB = 25;
  // Command fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_PORT_LSB = 2;
  localparam int CMD_IDX_LSB = 4;
  // Status fields
  localparam int ST_DROP_LSB = 0;
  localparam int ST_FWD_LSB = 16;

  typedef enum logic [1:0] {ACC_ALL, ACC_TAGGED, ACC_UNTAGGED} vtf_acc_t;
  typedef enum logic [1:0] {CTL_NORMAL, CTL_FIXED, CTL_FORBID} vtf_ctl_t;
  typedef enum logic [1:0] {OP_NONE, OP_JOIN, OP_LEAVE, OP_LEAVE_ALL} vtf_op_t;
  typedef enum logic [1:0] {ST_RX, ST_DECIDE, ST_TX} vtf_state_t;
endpackage

// File: core/vtf_forward.sv
// Purpose: VLAN classify, filter, flood and tag rewrite of one frame at a time
// Assumes: Stream inputs synchronous to pclk; sideband valid with in_sop
// Notes:   Frame is stored whole, then replayed once per egress port
//
// How it works
// - A tagged frame has TPID in type position and TCI after the source address.
// - TCI is three priority bits, one CFI bit, twelve VID bits, independent.
// - Tags the block inserts into untagged frames always carry CFI zero.
// - A frame received with CFI one never leaves an untagged port.
// - VID zero is a priority frame: keep priority, use ingress default VID.
// - Only VIDs 1 to 4094 may be configured; 4095 is reserved.
// - Forwarding is decided first, then the tag is stripped toward untagged ports.
// - Untagged frames get destinations first, then a tag with ingress default VID.
// - Every port default VID resets to one and is software writable.
// - Flooded frames go only to member ports of the VID (to trunking ports if the VID is unknown), never to ingress.
// - Membership control per port and VLAN is fixed, forbidden or normal.
// - Tagged member ports send frames with a tag, untagged ones without.
// - Each port accepts all, only tagged, or only untagged frames.
// - Ingress filtering drops frames whose VLAN lacks the ingress port.
// - Unknown VIDs pass only through trunking ports, otherwise dropped.
// - Join declares membership, Leave withdraws it, Leave All clears one port's registration in every VLAN.
// - Inserted tags take the ingress port default priority.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module vtf_forward
  import vtf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic [1:0] in_port,
  input wire logic in_uc_known,
  input wire logic [1:0] in_uc_port,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic out_sop,
  output logic out_eop,
  output logic [1:0] out_port
);
  import vtf_pkg::*;

  logic [31:0] port_cfg [NPORT];
  logic [11:0] vlan_vid [NVLAN];
  logic [NVLAN-1:0] vlan_valid;
  logic [7:0] vlan_ctl [NVLAN];
  logic [NPORT-1:0] vlan_tag [NVLAN];
  logic [NPORT-1:0] vlan_dyn [NVLAN];
  logic [NPORT-1:0] vlan_member [NVLAN];
  logic [15:0] drop_cnt;
  logic [15:0] fwd_cnt;
  logic [7:0] mem [MEM_DEPTH];
  vtf_state_t state;
  logic [11:0] rx_cnt;
  logic rx_over;
  logic [11:0] rx_len;
  logic [15:0] fr_type;
  logic [15:0] fr_tci;
  logic fr_group;
  logic [1:0] fr_port;
  logic fr_uc_known;
  logic [1:0] fr_uc_port;
  logic [NPORT-1:0] send_mask;
  logic [NPORT-1:0] tag_mask;
  logic tx_busy;
  logic [1:0] tx_port;
  logic [11:0] tx_k;
  logic [31:0] crc;
  logic spare_valid;
  logic [11:0] spare;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one-cycle answer, no wait states
  logic apb_wr;
  logic is_port;
  logic is_vlan;
  logic [2:0] widx;
  logic [31:0] next_rdata;
  logic next_err;
  assign apb_wr = psel & penable & pready & pwrite;
  assign is_port = (paddr[11:4] == REG_PORT0[11:4]) && (paddr[1:0] == 2'h0);
  assign is_vlan = (paddr[11:5] == REG_VLAN0[11:5]) && (paddr[1:0] == 2'h0);
  assign widx = paddr[4:2];

  // Read mux; VLAN entries also show live registration bits
  always_comb
  begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    if (paddr == REG_STAT)
      next_rdata = {fwd_cnt, drop_cnt};
    else if (paddr == REG_CMD)
      next_rdata = 32'h00000000;
    else if (is_port)
      next_rdata = port_cfg[widx[1:0]];
    else if (is_vlan)
      next_rdata = {3'h0, vlan_dyn[widx], vlan_tag[widx], vlan_ctl[widx], vlan_valid[widx], vlan_vid[widx]};
    else
      next_err = 1'b1;
  end

  // Answer registered in the setup cycle, so the access cycle completes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      prdata <= (psel & ~penable & ~pwrite) ? next_rdata : 32'h00000000;
      pslverr <= psel & ~penable & next_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int p = 0; p < NPORT; p++)
        port_cfg[p] <= PC_RST;
    end
    else if (apb_wr && is_port)
      port_cfg[widx[1:0]] <= pwdata & PC_MASK;
  end

  // VLAN table; reserved and priority VIDs never become valid
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NVLAN; i++)
      begin
        vlan_vid[i] <= 12'h000;
        vlan_ctl[i] <= 8'h00;
        vlan_tag[i] <= '0;
      end
      vlan_valid <= '0;
    end
    else if (apb_wr && is_vlan)
    begin
      vlan_vid[widx] <= pwdata[VE_VID_LSB +: 12];
      vlan_ctl[widx] <= pwdata[VE_CTL_LSB +: 8];
      vlan_tag[widx] <= pwdata[VE_TAG_LSB +: NPORT];
      vlan_valid[widx] <= pwdata[VE_VALID_BIT] && pwdata[11:0] != VID_PRIO
                          && pwdata[11:0] != VID_RSVD;
    end
  end

  // Registration messages; a forbidden port never joins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NVLAN; i++)
        vlan_dyn[i] <= '0;
    end
    else if (apb_wr && paddr == REG_CMD)
    begin
      unique case (pwdata[CMD_OP_LSB +: 2])
        OP_JOIN:
          if (vlan_ctl[pwdata[CMD_IDX_LSB +: 3]][2*pwdata[CMD_PORT_LSB +: 2] +: 2] == CTL_NORMAL)
            vlan_dyn[pwdata[CMD_IDX_LSB +: 3]][pwdata[CMD_PORT_LSB +: 2]] <= 1'b1;
        OP_LEAVE:
          vlan_dyn[pwdata[CMD_IDX_LSB +: 3]][pwdata[CMD_PORT_LSB +: 2]] <= 1'b0;
        OP_LEAVE_ALL:
          for (int i = 0; i < NVLAN; i++)
            vlan_dyn[i][pwdata[CMD_PORT_LSB +: 2]] <= 1'b0;
        OP_NONE:
          ;
      endcase
    end
  end

  // Member when fixed, or normal and registered
  for (genvar gi = 0; gi < NVLAN; gi++)
  begin : g_member
    for (genvar gp = 0; gp < NPORT; gp++)
    begin : g_port
      assign vlan_member[gi][gp] = vlan_ctl[gi][2*gp +: 2] == CTL_FIXED
                                   || (vlan_ctl[gi][2*gp +: 2] == CTL_NORMAL && vlan_dyn[gi][gp]);
    end
    property p_vid_range;
      @(posedge pclk) disable iff (!presetn)
      vlan_valid[gi] |-> vlan_vid[gi] != VID_PRIO && vlan_vid[gi] != VID_RSVD;
    endproperty
    a_vid_range: assert property (p_vid_range) else $error("reserved VID marked valid");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame classification from the captured header
  logic fr_tagged;
  logic [11:0] fr_vid;
  logic [2:0] fr_pri;
  logic fr_cfi;
  logic [31:0] in_cfg;
  logic hit;
  logic [2:0] hit_idx;
  logic drop;
  logic [NPORT-1:0] dest;
  logic [NPORT-1:0] trunk_ports;
  assign in_cfg = port_cfg[fr_port];
  assign fr_tagged = fr_type == TPID && rx_len >= MIN_TAG;
  assign fr_vid = (fr_tagged && fr_tci[11:0] != VID_PRIO) ? fr_tci[11:0]
                  : in_cfg[PC_PVID_LSB +: 12];
  assign fr_pri = fr_tagged ? fr_tci[15:13] : in_cfg[PC_PRI_LSB +: 3];
  assign fr_cfi = fr_tagged & fr_tci[12];

  always_comb
  begin
    hit = 1'b0;
    hit_idx = 3'h0;
    for (int i = NVLAN - 1; i >= 0; i--)
      if (vlan_valid[i] && vlan_vid[i] == fr_vid)
      begin
        hit = 1'b1;
        hit_idx = 3'(i);
      end
    for (int p = 0; p < NPORT; p++)
      trunk_ports[p] = port_cfg[p][PC_TRUNK_BIT];
  end

  // Drop reasons, then destination set without the ingress port
  always_comb
  begin
    drop = rx_len < MIN_UNTAG;
    if (in_cfg[PC_ACC_LSB +: 2] == ACC_TAGGED && !fr_tagged)
      drop = 1'b1;
    if (in_cfg[PC_ACC_LSB +: 2] == ACC_UNTAGGED && fr_tagged)
      drop = 1'b1;
    if (fr_tagged && fr_tci[11:0] == VID_RSVD)
      drop = 1'b1;
    if (!hit && !in_cfg[PC_TRUNK_BIT])
      drop = 1'b1;
    if (hit && in_cfg[PC_FILT_BIT] && !vlan_member[hit_idx][fr_port])
      drop = 1'b1;
    dest = hit ? vlan_member[hit_idx] : trunk_ports;
    dest[fr_port] = 1'b0;
    if (fr_uc_known && !fr_group)
      dest = dest & (NPORT'(1) << fr_uc_port);
    for (int p = 0; p < NPORT; p++)
      if (fr_cfi && hit && !vlan_tag[hit_idx][p])
        dest[p] = 1'b0;
    if (drop)
      dest = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ingress: store the frame and capture header fields
  logic rx_fire;
  assign rx_fire = in_valid & in_ready;

  always_ff @(posedge pclk)
  begin
    if (rx_fire && !rx_cnt[11])
      mem[rx_cnt[AW-1:0]] <= in_data;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_cnt <= 12'h000;
      rx_over <= 1'b0;
      rx_len <= 12'h000;
      fr_type <= 16'h0000;
      fr_tci <= 16'h0000;
      fr_group <= 1'b0;
      fr_port <= 2'h0;
      fr_uc_known <= 1'b0;
      fr_uc_port <= 2'h0;
    end
    else if (rx_fire)
    begin
      rx_cnt <= in_eop ? 12'h000 : (rx_cnt == MAX_FRAME ? rx_cnt : rx_cnt + 12'h001);
      rx_over <= in_eop ? 1'b0 : (rx_over | rx_cnt == MAX_FRAME);
      if (in_eop)
        rx_len <= (rx_over || rx_cnt == MAX_FRAME) ? 12'h000 : rx_cnt + 12'h001;
      if (in_sop)
      begin
        fr_group <= in_data[0];
        fr_port <= in_port;
        fr_uc_known <= in_uc_known;
        fr_uc_port <= in_uc_port;
      end
      if (rx_cnt == HDR_LEN)
        fr_type[15:8] <= in_data;
      if (rx_cnt == HDR_LEN + 12'h001)
        fr_type[7:0] <= in_data;
      if (rx_cnt == HDR_LEN + 12'h002)
        fr_tci[15:8] <= in_data;
      if (rx_cnt == HDR_LEN + 12'h003)
        fr_tci[7:0] <= in_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Egress byte generator
  logic buf_ready;
  logic push;
  logic tx_tag;
  logic [11:0] hl;
  logic [11:0] src_off;
  logic [11:0] tx_len;
  logic [11:0] src_idx;
  logic [7:0] push_data;
  logic tx_last;
  assign buf_ready = ~spare_valid;
  assign push = state == ST_TX && tx_busy && buf_ready;
  assign tx_tag = tag_mask[tx_port];
  assign hl = tx_tag ? HDR_LEN + TAG_LEN : HDR_LEN;
  assign src_off = fr_tagged ? HDR_LEN + TAG_LEN : HDR_LEN;
  assign tx_len = rx_len - src_off + hl;
  assign src_idx = tx_k - hl + src_off;
  assign tx_last = tx_k == tx_len - 12'h001;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int b = 0; b < 8; b++)
      r = (r >> 1) ^ ((r[0] ^ d[b]) ? CRC_POLY : 32'h00000000);
    return r;
  endfunction

  // Header, rebuilt tag, body, then a fresh check sequence
  always_comb
  begin
    if (tx_k < HDR_LEN)
      push_data = mem[tx_k[AW-1:0]];
    else if (tx_k < hl && tx_k == HDR_LEN)
      push_data = TPID[15:8];
    else if (tx_k < hl && tx_k == HDR_LEN + 12'h001)
      push_data = TPID[7:0];
    else if (tx_k < hl && tx_k == HDR_LEN + 12'h002)
      push_data = {fr_pri, fr_cfi, fr_vid[11:8]};
    else if (tx_k < hl)
      push_data = fr_vid[7:0];
    else if (tx_k < tx_len - FCS_LEN)
      push_data = mem[src_idx[AW-1:0]];
    else
      push_data = ~crc[8*(tx_k - (tx_len - FCS_LEN)) +: 8];
  end

  // Frame sequencing: receive, decide once, replay per port
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_RX;
      in_ready <= 1'b0;
      send_mask <= '0;
      tag_mask <= '0;
      tx_busy <= 1'b0;
      tx_port <= 2'h0;
      tx_k <= 12'h000;
      crc <= CRC_INIT;
    end
    else
    begin
      unique case (state)
        ST_RX:
        begin
          in_ready <= ~(rx_fire & in_eop);
          if (rx_fire && in_eop)
            state <= ST_DECIDE;
        end
        ST_DECIDE:
        begin
          send_mask <= dest;
          tag_mask <= hit ? vlan_tag[hit_idx] : '1;
          state <= ST_TX;
        end
        ST_TX:
        begin
          if (!tx_busy && send_mask == '0)
          begin
            state <= ST_RX;
            in_ready <= 1'b1;
          end
          else if (!tx_busy)
          begin
            tx_busy <= 1'b1;
            tx_k <= 12'h000;
            crc <= CRC_INIT;
            for (int p = NPORT - 1; p >= 0; p--)
              if (send_mask[p])
                tx_port <= 2'(p);
          end
          else if (push)
          begin
            tx_k <= tx_k + 12'h001;
            if (tx_k < tx_len - FCS_LEN)
              crc <= crc_byte(crc, push_data);
            if (tx_last)
            begin
              tx_busy <= 1'b0;
              send_mask[tx_port] <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // Statistics taken at the decision point
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drop_cnt <= 16'h0000;
      fwd_cnt <= 16'h0000;
    end
    else if (state == ST_DECIDE)
    begin
      if (dest == '0)
        drop_cnt <= drop_cnt + 16'h0001;
      else
        fwd_cnt <= fwd_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer; spare slot absorbs a stall without loss
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_valid <= 1'b0;
      out_data <= 8'h00;
      out_sop <= 1'b0;
      out_eop <= 1'b0;
      out_port <= 2'h0;
      spare_valid <= 1'b0;
      spare <= 12'h000;
    end
    else if (!out_valid || out_ready)
    begin
      if (spare_valid)
      begin
        {out_port, out_sop, out_eop, out_data} <= spare;
        out_valid <= 1'b1;
        spare_valid <= 1'b0;
      end
      else
      begin
        {out_port, out_sop, out_eop, out_data} <= {tx_port, tx_k == 12'h000, tx_last, push_data};
        out_valid <= push;
      end
    end
    else if (push)
    begin
      spare <= {tx_port, tx_k == 12'h000, tx_last, push_data};
      spare_valid <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_cfi_zero;
    @(posedge pclk) disable iff (!presetn)
    push && tx_tag && !fr_tagged && tx_k == HDR_LEN + 12'h002 |-> !push_data[4];
  endproperty
  a_cfi_zero: assert property (p_cfi_zero) else $error("generated tag has CFI set");

  property p_cfi_untag;
    @(posedge pclk) disable iff (!presetn)
    push && !tx_tag |-> !fr_cfi;
  endproperty
  a_cfi_untag: assert property (p_cfi_untag) else $error("CFI frame sent untagged");

  property p_no_ingress;
    @(posedge pclk) disable iff (!presetn)
    state == ST_DECIDE |=> !send_mask[fr_port];
  endproperty
  a_no_ingress: assert property (p_no_ingress) else $error("frame sent back to ingress");

  property p_tag_vid;
    @(posedge pclk) disable iff (!presetn)
    push && tx_tag && tx_k == HDR_LEN + 12'h003 |-> push_data == fr_vid[7:0];
  endproperty
  a_tag_vid: assert property (p_tag_vid) else $error("tag VID wrong");

  property p_tag_mark;
    @(posedge pclk) disable iff (!presetn)
    push && tx_k == HDR_LEN |-> (push_data == TPID[15:8]) == tx_tag || !tx_tag;
  endproperty
  a_tag_mark: assert property (p_tag_mark) else $error("tagged port lacks tag");

  property p_accept;
    @(posedge pclk) disable iff (!presetn)
    state == ST_DECIDE && in_cfg[PC_ACC_LSB +: 2] == ACC_TAGGED && !fr_tagged |=> send_mask == '0 ##1 state == ST_RX;
  endproperty
  a_accept: assert property (p_accept) else $error("untagged frame accepted");

  property p_filter;
    @(posedge pclk) disable iff (!presetn)
    state == ST_DECIDE && hit && in_cfg[PC_FILT_BIT] && !vlan_member[hit_idx][fr_port] |=> send_mask == '0;
  endproperty
  a_filter: assert property (p_filter) else $error("filtered frame forwarded");

  property p_unknown;
    @(posedge pclk) disable iff (!presetn)
    state == ST_DECIDE && !hit && !in_cfg[PC_TRUNK_BIT] |=> send_mask == '0;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown VID passed");

  property p_stall_hold;
    @(posedge pclk) disable iff (!presetn)
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("output lost under stall");

  c_tagged_out: cover property (@(posedge pclk) disable iff (!presetn) push && tx_tag && !fr_tagged && tx_last);
  c_stripped: cover property (@(posedge pclk) disable iff (!presetn) push && !tx_tag && fr_tagged && tx_last);
  c_dropped: cover property (@(posedge pclk) disable iff (!presetn) state == ST_DECIDE && dest == '0);
  c_spare_full: cover property (@(posedge pclk) disable iff (!presetn) spare_valid);
endmodule // vtf_forward

// File: verif/vtf_sink.sv
// Purpose: Egress sink standing in for the peer stations
// Assumes: Byte stream egress of the forwarding block
// Notes:   Stalls at random so the output buffer fills and drains
`timescale 1ns/1ns
module vtf_sink
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] stall_pct,
  output logic out_ready
);
  // Random back-pressure; level zero never stalls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_ready <= 1'b0;
    else
      out_ready <= 4'($urandom % 16) >= stall_pct;
  end
endmodule // vtf_sink

// File: verif/vlan_tag_forwarding_tb_top.sv
// Purpose: Self-checking bench of the VLAN tag forwarding block
// Assumes: APB slave answers within a bounded wait
// Notes:   Driver queues expected egress bytes, monitor pops them
`timescale 1ns/1ns
module vlan_tag_forwarding_tb_top;
  import vtf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic in_valid, in_ready, in_sop, in_eop, out_valid, out_ready, out_sop, out_eop;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] in_data, out_data;
  logic [1:0] in_port, out_port;
  logic [3:0] stall;
  logic uc_known;
  logic [1:0] uc_port;
  logic [11:0] expq[$];
  logic [7:0] hdr[$], body[$];
  int mismatches, num_checks;

  // Unicast lookup result driven by the bench; one scenario limits a frame to one port
  vtf_forward vtf_forward_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .in_valid, .in_ready, .in_data, .in_sop, .in_eop, .in_port, .in_uc_known(uc_known), .in_uc_port(uc_port),
    .out_valid, .out_ready, .out_data, .out_sop, .out_eop, .out_port);
  vtf_sink vtf_sink_inst (.pclk, .presetn, .stall_pct(stall), .out_ready);

  ////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic give_up();
    mismatches++;
    $display("BAD %0t timeout exp %h got %h", $time, 1'b1, 1'b0);
    summarize();
  endtask

  task automatic chk_byte(input logic [11:0] e, input logic [11:0] g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %0t byte exp %h got %h", $time, e, g);
    end
  endtask

  task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %0t word exp %h got %h", $time, e, g);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 50)
      give_up();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Standard Ethernet CRC, reflected, sent low byte first
  function automatic logic [31:0] crc_of(input logic [7:0] f[$]);
    logic [31:0] c;
    c = CRC_INIT;
    foreach (f[i])
    begin
      c = c ^ {24'h000000, f[i]};
      repeat (8)
        c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction

  function automatic void build(input logic tg, input logic [15:0] tci, ref logic [7:0] q[$]);
    logic [31:0] c;
    q = hdr;
    if (tg)
      q = {q, TPID[15:8], TPID[7:0], tci[15:8], tci[7:0]};
    q = {q, body};
    c = crc_of(q);
    q = {q, c[7:0], c[15:8], c[23:16], c[31:24]};
  endfunction

  // Byte stream driver; each byte held until in_ready is sampled high
  task automatic send(input logic [1:0] p, input logic [7:0] f[$]);
    int n;
    @(posedge pclk);
    foreach (f[i])
    begin
      in_valid <= 1'b1;
      in_data <= f[i];
      in_sop <= (i == 0);
      in_eop <= (i == f.size() - 1);
      in_port <= p;
      for (n = 0; n < 2000; n++)
      begin
        @(posedge pclk);
        if (in_ready === 1'b1)
          break;
      end
      if (n == 2000)
        give_up();
    end
    in_valid <= 1'b0;
    in_sop <= 1'b0;
    in_eop <= 1'b0;
  endtask

  // One frame in; expected copies per egress port, lowest port first
  task automatic run(input logic [1:0] p, input logic tg, input logic [15:0] ti, input logic [15:0] to,
                     input logic [3:0] dst, input logic [3:0] tgm);
    logic [7:0] f[$], e[$];
    int n;
    body = {8'h08, 8'h00};
    repeat (6)
      body.push_back(8'($urandom));
    build(tg, ti, f);
    for (int k = 0; k < NPORT; k++)
      if (dst[k])
      begin
        build(tgm[k], to, e);
        foreach (e[i])
          expq.push_back({2'(k), i == 0, i == e.size() - 1, e[i]});
      end
    send(p, f);
    for (n = 0; n < 3000; n++)
    begin
      @(posedge pclk);
      if (expq.size() == 0 && in_ready === 1'b1)
        break;
    end
    if (n == 3000)
      give_up();
    repeat (20)
      @(posedge pclk);
    chk_word(32'h00000000, 32'(expq.size()));
    $display("test done port %0d tci %h", p, ti);
  endtask

  ////////////////////////////////////////////////////////////
  // Clock, 50 ns period
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Egress monitor; a byte with nothing queued is unexpected
  always @(posedge pclk)
  begin
    if (presetn === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1)
      chk_byte(expq.size() > 0 ? expq.pop_front() : 12'hxxx, {out_port, out_sop, out_eop, out_data});
  end

  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, in_valid, in_sop, in_eop, err} = 8'h00;
    {paddr, pwdata, rd, in_data, in_port, stall} = 90'h0;
    {uc_known, uc_port} = 3'h0;
    void'($urandom(70));
    hdr = {8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    repeat (6)
      hdr.push_back(8'($urandom));
    repeat (16)
      @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_PORT0, 32'h00000000);
    chk_word(PC_RST, rd);
    apb(1'b0, 12'h0f0, 32'h00000000);
    chk_word(32'h00000001, {31'h00000000, err});
    apb(1'b1, REG_PORT0, 32'h00003005);
    apb(1'b0, REG_PORT0, 32'h00000000);
    chk_word(32'h00003005, rd);
    apb(1'b1, REG_VLAN0, 32'h004ab005);
    run(2'd0, 1'b0, 16'h0000, 16'h6005, 4'b1110, 4'b0010);
    stall <= 4'h8;
    run(2'd1, 1'b1, 16'h4005, 16'h4005, 4'b1101, 4'b0000);
    // Known unicast destination narrows the member set to one port
    hdr[0] = 8'h02;
    uc_known <= 1'b1;
    uc_port <= 2'd3;
    run(2'd1, 1'b1, 16'h4005, 16'h4005, 4'b1000, 4'b0000);
    uc_known <= 1'b0;
    hdr[0] = 8'hff;
    run(2'd0, 1'b1, 16'he000, 16'he005, 4'b1110, 4'b0010);
    run(2'd1, 1'b1, 16'h5005, 16'h0000, 4'b0000, 4'b0000);
    run(2'd0, 1'b1, 16'h2009, 16'h0000, 4'b0000, 4'b0000);
    run(2'd0, 1'b1, 16'h2fff, 16'h0000, 4'b0000, 4'b0000);
    apb(1'b1, 12'h044, 32'h00001007);
    run(2'd0, 1'b1, 16'h2007, 16'h2007, 4'b0000, 4'b0000);
    apb(1'b1, REG_CMD, 32'h00000019);
    apb(1'b0, 12'h044, 32'h00000000);
    chk_word(32'h08001007, rd);
    run(2'd0, 1'b1, 16'h2007, 16'h2007, 4'b0100, 4'b0000);
    // Port 3 tagged only, filtering, trunking; port 2 trunking
    apb(1'b1, 12'h01c, 32'h00068005);
    run(2'd3, 1'b1, 16'h2007, 16'h2007, 4'b0000, 4'b0000);
    run(2'd3, 1'b0, 16'h0000, 16'h0000, 4'b0000, 4'b0000);
    apb(1'b1, 12'h018, 32'h00040001);
    run(2'd3, 1'b1, 16'h2009, 16'h2009, 4'b0100, 4'b0100);
    apb(1'b1, REG_CMD, 32'h0000001a);
    apb(1'b0, 12'h044, 32'h00000000);
    chk_word(32'h00001007, rd);
    apb(1'b1, REG_CMD, 32'h00000019);
    apb(1'b1, REG_CMD, 32'h0000000b);
    run(2'd0, 1'b1, 16'h2007, 16'h2007, 4'b0000, 4'b0000);
    summarize();
  end
endmodule // vlan_tag_forwarding_tb_top
